// *** core/dcsc_control.sv ***
// display cache sdram special modes, refresh and detect register port
//
// Contract
// R1: rate field 01 (reset) refreshes periodically, 00 stops refresh; 10/11 reserved.
// R2: software keeps refresh disabled only briefly and restores it after testing.
// R3: selector 000 (reset) gives ordinary accesses; 101 and 11x are reserved.
// R4: selector 001 turns each cache host cycle into an sdram nop.
// R5: selector 010 turns each cache host cycle into an all bank precharge.
// R6: selector 011 turns each cache host cycle into mode register set on address lines.
// R7: mode register set: bits 2:0 burst, bit 3 wrap, bits 6:4 cas latency.
// R8: mode register set drives address bits 11:7 to zero always.
// R9: software selects the nop mode before any other special mode.
// R10: software picks host addresses so translation yields the wanted bits 6:0.
// R11: selector 100 turns each cache host cycle into a cbr refresh.
// R12: special command replaces the read or write; host cycle still completes.
// R13: registers answer in i/o and memory space at the same address value; the code answers control high in memory space only.
// R14: index low nibble selects the graphics register behind the data port.
// R15: index upper nibble always reads zero.
// R16: legacy control written at one address, read at another, resets to zero.
// R17: legacy enable 0 refuses legacy window cycles unclaimed; 1 reaches the cache.
// R18: legacy enable never blocks linear frame buffer accesses.
`timescale 1ns/1ps
module dcsc_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic regReq,
    input wire logic regWrite,
    input wire logic regMem,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic regAck,
    output logic [7:0] regRdata,
    input wire logic hostReq,
    input wire logic hostWrite,
    input wire logic [31:0] hostAddr,
    output logic hostClaim,
    output logic hostDone,
    output dcsc_pkg::dcsc_mem_t memOut,
    output logic [1:0] refreshRate,
    output logic [2:0] specialMode
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctlHigh_ff, nxt_ctlHigh;
    logic [7:0] legacy_ff, nxt_legacy;
    logic [7:0] grIndex_ff, nxt_grIndex;
    logic [7:0] grFile_ff [16];
    logic [7:0] nxt_grData;
    logic grWrite;
    logic [7:0] rdata_ff, nxt_rdata;
    logic regHit;

    // i/o and memory space share one decode; control high is memory only
    always_comb begin
        regHit = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_ctlHigh = ctlHigh_ff;
        nxt_legacy = legacy_ff;
        nxt_grIndex = grIndex_ff;
        nxt_grData = regWdata;
        grWrite = 1'b0;
        if (regReq) begin
            unique case (regAddr) // R13
                dcsc_pkg::LEGACY_WR_ADDR: begin
                    regHit = regWrite; // R16
                    if (regWrite) begin
                        nxt_legacy = regWdata & (8'h01 << dcsc_pkg::LEGACY_EN_BIT);
                    end
                end
                dcsc_pkg::LEGACY_RD_ADDR: begin
                    regHit = !regWrite; // R16
                    if (!regWrite) begin
                        nxt_rdata = legacy_ff;
                    end
                end
                dcsc_pkg::GR_INDEX_ADDR: begin
                    regHit = 1'b1;
                    if (regWrite) begin
                        nxt_grIndex = {4'h0, regWdata[dcsc_pkg::IDX_MSB:0]}; // R15
                    end else begin
                        nxt_rdata = grIndex_ff; // R15
                    end
                end
                dcsc_pkg::GR_DATA_ADDR: begin
                    regHit = 1'b1;
                    grWrite = regWrite; // R14
                    if (!regWrite) begin
                        nxt_rdata = grFile_ff[grIndex_ff[dcsc_pkg::IDX_MSB:0]]; // R14
                    end
                end
                dcsc_pkg::CTL_HIGH_ADDR: begin
                    regHit = regMem;
                    if (regMem && regWrite) begin
                        nxt_ctlHigh = {3'h0, regWdata[dcsc_pkg::RATE_MSB:0]};
                    end else if (regMem) begin
                        nxt_rdata = ctlHigh_ff;
                    end
                end
                default: regHit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctlHigh_ff <= dcsc_pkg::CTL_HIGH_RESET; // R1 R3
            legacy_ff <= dcsc_pkg::LEGACY_RESET; // R16
            grIndex_ff <= dcsc_pkg::GR_INDEX_RESET;
            rdata_ff <= 8'h00;
        end else begin
            ctlHigh_ff <= nxt_ctlHigh;
            legacy_ff <= nxt_legacy;
            grIndex_ff <= nxt_grIndex;
            rdata_ff <= nxt_rdata;
        end
    end

    // graphics register file has no reset, as its contents are undefined at power up
    always_ff @(posedge clk) begin
        if (grWrite) begin
            grFile_ff[grIndex_ff[dcsc_pkg::IDX_MSB:0]] <= nxt_grData;
        end
    end

    assign regAck = regHit;
    assign regRdata = rdata_ff;
    assign refreshRate = ctlHigh_ff[dcsc_pkg::RATE_MSB:dcsc_pkg::RATE_LSB];
    assign specialMode = ctlHigh_ff[dcsc_pkg::MODE_MSB:0];

    ////////////////////////////////////////////////////////////////////////////
    logic inLegacy, inLfb, legacyEn;
    dcsc_pkg::dcsc_claim_t claim;
    logic [11:0] xlatAddr;

    always_comb begin
        legacyEn = legacy_ff[dcsc_pkg::LEGACY_EN_BIT];
        inLegacy = hostAddr >= dcsc_pkg::LEGACY_LO && hostAddr <= dcsc_pkg::LEGACY_HI;
        inLfb = hostAddr >= dcsc_pkg::LFB_BASE && hostAddr - dcsc_pkg::LFB_BASE < dcsc_pkg::LFB_SIZE;
        claim = dcsc_pkg::HOST_NONE;
        if (hostReq && inLegacy) begin
            claim = legacyEn ? dcsc_pkg::HOST_CLAIMED : dcsc_pkg::HOST_REFUSED; // R17
        end else if (hostReq && inLfb) begin
            claim = dcsc_pkg::HOST_CLAIMED; // R18
        end
        xlatAddr = hostAddr[dcsc_pkg::XLAT_LSB +: 12];
    end

    assign hostClaim = claim == dcsc_pkg::HOST_CLAIMED;

    ////////////////////////////////////////////////////////////////////////////
    localparam int REFRESH_W = dcsc_pkg::REFRESH_CNT_W;
    logic [REFRESH_W-1:0] refCnt_ff, nxt_refCnt;
    logic refPend_ff, nxt_refPend;
    logic done_ff, nxt_done;
    dcsc_pkg::dcsc_mem_t mem_ff, nxt_mem;
    logic refDue;

    always_comb begin
        refDue = refCnt_ff == REFRESH_W'(dcsc_pkg::REFRESH_CYCLES - 1);
        nxt_refCnt = refDue ? '0 : refCnt_ff + 1'b1;
        nxt_refPend = refPend_ff;
        if (refreshRate != dcsc_pkg::RATE_ON) begin
            nxt_refCnt = '0; // R1
            nxt_refPend = 1'b0; // R1
        end else if (refDue) begin
            nxt_refPend = 1'b1; // R1
        end
        nxt_mem = dcsc_pkg::MEM_IDLE;
        nxt_done = hostClaim; // R12
        if (hostClaim) begin
            nxt_mem.addr = xlatAddr;
            unique case (specialMode)
                dcsc_pkg::MODE_NORMAL: nxt_mem.cmd = hostWrite ? dcsc_pkg::CMD_WRITE : dcsc_pkg::CMD_READ; // R3
                dcsc_pkg::MODE_NOP: nxt_mem.cmd = dcsc_pkg::CMD_NOP; // R4
                dcsc_pkg::MODE_PRECHARGE: begin
                    nxt_mem.cmd = dcsc_pkg::CMD_PRE; // R5
                    nxt_mem.addr[dcsc_pkg::AP_BIT] = 1'b1; // R5
                end
                dcsc_pkg::MODE_MRS: begin
                    nxt_mem.cmd = dcsc_pkg::CMD_MRS; // R6
                    nxt_mem.addr = {5'h00, xlatAddr[dcsc_pkg::MRS_LOW_MSB:0]}; // R7 R8
                end
                dcsc_pkg::MODE_CBR: nxt_mem.cmd = dcsc_pkg::CMD_CBR; // R11
                default: nxt_mem.cmd = dcsc_pkg::CMD_NOP; // R3
            endcase
        end else if (refPend_ff && !refDue && refreshRate == dcsc_pkg::RATE_ON) begin // R1
            nxt_mem.cmd = dcsc_pkg::CMD_CBR; // R1
            nxt_refPend = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            refCnt_ff <= '0;
            refPend_ff <= 1'b0;
            done_ff <= 1'b0;
            mem_ff <= dcsc_pkg::MEM_IDLE;
        end else begin
            refCnt_ff <= nxt_refCnt;
            refPend_ff <= nxt_refPend;
            done_ff <= nxt_done;
            mem_ff <= nxt_mem;
        end
    end

    assign hostDone = done_ff;
    assign memOut = mem_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_REFRESH_OFF: assert property ( // R1
        (refreshRate == dcsc_pkg::RATE_OFF) [*2] ##0 !$past(hostClaim) |-> memOut.cmd != dcsc_pkg::CMD_CBR
    ) else $error("refresh issued while disabled");
    AST_NOP_MODE: assert property ( // R4
        hostClaim && specialMode == dcsc_pkg::MODE_NOP |=> memOut.cmd == dcsc_pkg::CMD_NOP
    ) else $error("nop mode did not give nop");
    AST_PRE_MODE: assert property ( // R5
        hostClaim && specialMode == dcsc_pkg::MODE_PRECHARGE |=>
            memOut.cmd == dcsc_pkg::CMD_PRE && memOut.addr[dcsc_pkg::AP_BIT]
    ) else $error("precharge mode did not give all bank precharge");
    AST_MRS_ADDR: assert property ( // R6
        hostClaim && specialMode == dcsc_pkg::MODE_MRS |=>
            memOut.cmd == dcsc_pkg::CMD_MRS && memOut.addr[6:0] == $past(hostAddr[8:2])
    ) else $error("mode register set operand wrong");
    AST_MRS_HIGH_ZERO: assert property ( // R8
        memOut.cmd == dcsc_pkg::CMD_MRS |-> memOut.addr[11:7] == 5'h00
    ) else $error("mode register set upper address not zero");
    AST_CBR_MODE: assert property ( // R11
        hostClaim && specialMode == dcsc_pkg::MODE_CBR |=> memOut.cmd == dcsc_pkg::CMD_CBR
    ) else $error("cbr mode did not give refresh");
    AST_NORMAL_MODE: assert property ( // R3
        hostClaim && specialMode == dcsc_pkg::MODE_NORMAL |=>
            memOut.cmd == ($past(hostWrite) ? dcsc_pkg::CMD_WRITE : dcsc_pkg::CMD_READ)
    ) else $error("normal mode access wrong");
    AST_HOST_DONE: assert property ( // R12
        hostClaim |=> hostDone ##1 !hostDone || $past(hostClaim)
    ) else $error("host cycle did not complete");
    AST_INDEX_UPPER: assert property ( // R15
        regReq && !regWrite && regAddr == dcsc_pkg::GR_INDEX_ADDR |=> regRdata[7:4] == 4'h0
    ) else $error("index upper nibble not zero");
    AST_LEGACY_BLOCK: assert property ( // R17
        hostReq && hostAddr >= dcsc_pkg::LEGACY_LO && hostAddr <= dcsc_pkg::LEGACY_HI
            |-> hostClaim == legacy_ff[dcsc_pkg::LEGACY_EN_BIT]
    ) else $error("legacy window claim wrong");
    AST_LFB_OPEN: assert property ( // R18
        hostReq && hostAddr >= dcsc_pkg::LFB_BASE && hostAddr - dcsc_pkg::LFB_BASE < dcsc_pkg::LFB_SIZE
            |-> hostClaim
    ) else $error("frame buffer access blocked");
    AST_LEGACY_WRITE_ONLY: assert property ( // R16
        regReq && regWrite && regAddr == dcsc_pkg::LEGACY_RD_ADDR |-> !regAck
    ) else $error("legacy read address took a write");

    COV_MRS: cover property (hostClaim && specialMode == dcsc_pkg::MODE_MRS ##1 hostDone);
    COV_REFRESH: cover property (refreshRate == dcsc_pkg::RATE_ON ##1 memOut.cmd == dcsc_pkg::CMD_CBR);
    COV_REFUSED: cover property (claim == dcsc_pkg::HOST_REFUSED);
    COV_GR_READ: cover property (regReq && !regWrite && regAddr == dcsc_pkg::GR_DATA_ADDR);
endmodule

// *** core/dcsc_pkg.sv ***
// shared constants and types for the display cache sdram control block
package dcsc_pkg;
    // register addresses, identical in i/o space and as memory offsets, except control high, which is a memory offset only
    localparam logic [15:0] LEGACY_WR_ADDR = 16'h03c2;
    localparam logic [15:0] LEGACY_RD_ADDR = 16'h03cc;
    localparam logic [15:0] GR_INDEX_ADDR = 16'h03ce;
    localparam logic [15:0] GR_DATA_ADDR = 16'h03cf;
    localparam logic [15:0] CTL_HIGH_ADDR = 16'h3002;
    // field layout and reset values
    localparam logic [7:0] CTL_HIGH_RESET = 8'h08;
    localparam logic [7:0] LEGACY_RESET = 8'h00;
    localparam logic [7:0] GR_INDEX_RESET = 8'h00;
    localparam int RATE_LSB = 3;
    localparam int RATE_MSB = 4;
    localparam int MODE_MSB = 2;
    localparam int LEGACY_EN_BIT = 1;
    localparam int IDX_MSB = 3;
    localparam logic [1:0] RATE_OFF = 2'h0;
    localparam logic [1:0] RATE_ON = 2'h1;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_NOP = 3'h1;
    localparam logic [2:0] MODE_PRECHARGE = 3'h2;
    localparam logic [2:0] MODE_MRS = 3'h3;
    localparam logic [2:0] MODE_CBR = 3'h4;
    // legacy window and linear frame buffer decode
    localparam logic [31:0] LEGACY_LO = 32'h000a_0000;
    localparam logic [31:0] LEGACY_HI = 32'h000b_ffff;
    localparam logic [31:0] LFB_BASE = 32'hd000_0000;
    localparam logic [31:0] LFB_SIZE = 32'h0040_0000;
    // address translation: dword address into memory address lines
    localparam int XLAT_LSB = 2;
    localparam int AP_BIT = 10;
    localparam int MRS_LOW_MSB = 6;
    // refresh interval, 15600 ns at 20 ns per cycle, rounded down
    localparam int CLK_PERIOD_NS = 20;
    localparam int REFRESH_NS = 15600;
    localparam int REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;
    localparam int REFRESH_CNT_W = 10;

    typedef struct packed {
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
    } dcsc_cmd_t;

    localparam dcsc_cmd_t CMD_NOP = '{csN: 1'b0, rasN: 1'b1, casN: 1'b1, weN: 1'b1};
    localparam dcsc_cmd_t CMD_DESEL = '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1};
    localparam dcsc_cmd_t CMD_PRE = '{csN: 1'b0, rasN: 1'b0, casN: 1'b1, weN: 1'b0};
    localparam dcsc_cmd_t CMD_MRS = '{csN: 1'b0, rasN: 1'b0, casN: 1'b0, weN: 1'b0};
    localparam dcsc_cmd_t CMD_CBR = '{csN: 1'b0, rasN: 1'b0, casN: 1'b0, weN: 1'b1};
    localparam dcsc_cmd_t CMD_READ = '{csN: 1'b0, rasN: 1'b1, casN: 1'b0, weN: 1'b1};
    localparam dcsc_cmd_t CMD_WRITE = '{csN: 1'b0, rasN: 1'b1, casN: 1'b0, weN: 1'b0};

    typedef struct packed {
        dcsc_cmd_t cmd;
        logic [11:0] addr;
    } dcsc_mem_t;

    localparam dcsc_mem_t MEM_IDLE = '{cmd: CMD_DESEL, addr: 12'h000};

    typedef enum logic [1:0] {
        HOST_NONE,
        HOST_CLAIMED,
        HOST_REFUSED
    } dcsc_claim_t;
endpackage

// *** sim/dcsc_sdram_model.sv ***
// behavioural model of the display cache sdram devices
`timescale 1ns/1ps
module dcsc_sdram_model (
    input wire logic clk,
    input wire logic rst,
    input wire dcsc_pkg::dcsc_mem_t memOut,
    output logic [15:0] refreshCount,
    output logic orderFault
);
    logic nopSeen;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            refreshCount <= 16'h0000;
            orderFault <= 1'b0;
            nopSeen <= 1'b0;
        end else begin
            if (memOut.cmd === dcsc_pkg::CMD_CBR) begin
                refreshCount <= refreshCount + 16'h0001;
            end
            if (memOut.cmd === dcsc_pkg::CMD_NOP) begin
                nopSeen <= 1'b1;
            end
            if (!nopSeen && (memOut.cmd === dcsc_pkg::CMD_MRS || memOut.cmd === dcsc_pkg::CMD_PRE)) begin
                orderFault <= 1'b1;
            end
        end
    end
endmodule

// *** sim/display_cache_sdram_init_control_test.sv ***
// self-checking testbench for the display cache sdram control block
`timescale 1ns/1ps
module display_cache_sdram_init_control_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic regReq = 1'b0, regWrite = 1'b0, regMem = 1'b0, regAck, hostReq = 1'b0, hostWrite = 1'b0;
    logic hostClaim, hostDone, orderFault;
    logic [15:0] regAddr = 16'h0000;
    logic [15:0] refreshCount;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic [31:0] hostAddr = 32'h0000_0000;
    logic [1:0] refreshRate;
    logic [2:0] specialMode;
    dcsc_pkg::dcsc_mem_t memOut;
    int numErrors = 0;
    int checksDone = 0;
    always #10 clk = ~clk;
    dcsc_control dut (.clk(clk), .rst(rst), .regReq(regReq), .regWrite(regWrite), .regMem(regMem),
        .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck), .regRdata(regRdata), .hostReq(hostReq),
        .hostWrite(hostWrite), .hostAddr(hostAddr), .hostClaim(hostClaim), .hostDone(hostDone),
        .memOut(memOut), .refreshRate(refreshRate), .specialMode(specialMode));
    dcsc_sdram_model model (.clk(clk), .rst(rst), .memOut(memOut), .refreshCount(refreshCount),
        .orderFault(orderFault));
    ////////////////////////////////////////////////////////////////
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkCmd(input dcsc_pkg::dcsc_cmd_t got, input dcsc_pkg::dcsc_cmd_t exp);
        check(32'(got), 32'(exp));
    endtask
    task automatic regAcc(input logic wr, input logic mem, input logic [15:0] addr, input logic [7:0] wd,
                          input logic expAck, input logic [7:0] expRd);
        @(negedge clk);
        regReq = 1'b1;
        regWrite = wr;
        regMem = mem;
        regAddr = addr;
        regWdata = wd;
        #1;
        check(32'(regAck), 32'(expAck));
        @(negedge clk);
        regReq = 1'b0;
        if (!wr && expAck) begin
            check(32'(regRdata), 32'(expRd));
        end
    endtask
    task automatic hostAcc(input logic wr, input logic [31:0] addr, input logic expClaim,
                           input dcsc_pkg::dcsc_cmd_t expCmd, output logic [11:0] gotAddr);
        @(negedge clk);
        hostReq = 1'b1;
        hostWrite = wr;
        hostAddr = addr;
        #1;
        check(32'(hostClaim), 32'(expClaim));
        @(negedge clk);
        hostReq = 1'b0;
        check(32'(hostDone), 32'(expClaim));
        checkCmd(memOut.cmd, expClaim ? expCmd : dcsc_pkg::CMD_DESEL);
        gotAddr = memOut.addr;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic testRegisters();
        regAcc(1'b0, 1'b1, dcsc_pkg::CTL_HIGH_ADDR, 8'h00, 1'b1, 8'h08);
        check(32'(refreshRate), 32'(dcsc_pkg::RATE_ON));
        check(32'(specialMode), 32'(dcsc_pkg::MODE_NORMAL));
        regAcc(1'b0, 1'b0, dcsc_pkg::LEGACY_RD_ADDR, 8'h00, 1'b1, 8'h00);
        regAcc(1'b0, 1'b0, dcsc_pkg::CTL_HIGH_ADDR, 8'h00, 1'b0, 8'h00);
        regAcc(1'b0, 1'b0, dcsc_pkg::LEGACY_WR_ADDR, 8'h00, 1'b0, 8'h00);
        regAcc(1'b1, 1'b0, dcsc_pkg::LEGACY_RD_ADDR, 8'hff, 1'b0, 8'h00);
        regAcc(1'b0, 1'b1, 16'h3003, 8'h00, 1'b0, 8'h00);
        regAcc(1'b1, 1'b0, dcsc_pkg::GR_INDEX_ADDR, 8'hf3, 1'b1, 8'h00);
        regAcc(1'b0, 1'b1, dcsc_pkg::GR_INDEX_ADDR, 8'h00, 1'b1, 8'h03);
        regAcc(1'b1, 1'b0, dcsc_pkg::GR_DATA_ADDR, 8'h5a, 1'b1, 8'h00);
        regAcc(1'b1, 1'b1, dcsc_pkg::GR_INDEX_ADDR, 8'h05, 1'b1, 8'h00);
        regAcc(1'b1, 1'b1, dcsc_pkg::GR_DATA_ADDR, 8'ha5, 1'b1, 8'h00);
        regAcc(1'b0, 1'b1, dcsc_pkg::GR_DATA_ADDR, 8'h00, 1'b1, 8'ha5);
        regAcc(1'b1, 1'b0, dcsc_pkg::GR_INDEX_ADDR, 8'h03, 1'b1, 8'h00);
        regAcc(1'b0, 1'b0, dcsc_pkg::GR_DATA_ADDR, 8'h00, 1'b1, 8'h5a);
        regAcc(1'b1, 1'b1, dcsc_pkg::CTL_HIGH_ADDR, 8'hff, 1'b1, 8'h00);
        regAcc(1'b0, 1'b1, dcsc_pkg::CTL_HIGH_ADDR, 8'h00, 1'b1, 8'h1f);
        regAcc(1'b1, 1'b1, dcsc_pkg::CTL_HIGH_ADDR, 8'h08, 1'b1, 8'h00);
        $display("register test done");
    endtask
    task automatic testLegacy();
        logic [11:0] a;
        hostAcc(1'b0, 32'h000a_0010, 1'b0, dcsc_pkg::CMD_DESEL, a);
        hostAcc(1'b0, 32'hd000_0100, 1'b1, dcsc_pkg::CMD_READ, a);
        check(32'(a), 32'h0000_0040);
        hostAcc(1'b0, 32'h0010_0000, 1'b0, dcsc_pkg::CMD_DESEL, a);
        regAcc(1'b1, 1'b0, dcsc_pkg::LEGACY_WR_ADDR, 8'hff, 1'b1, 8'h00);
        regAcc(1'b0, 1'b1, dcsc_pkg::LEGACY_RD_ADDR, 8'h00, 1'b1, 8'h02);
        hostAcc(1'b0, 32'h000b_fffc, 1'b1, dcsc_pkg::CMD_READ, a);
        regAcc(1'b1, 1'b1, dcsc_pkg::LEGACY_WR_ADDR, 8'h00, 1'b1, 8'h00);
        hostAcc(1'b1, 32'hd000_0100, 1'b1, dcsc_pkg::CMD_WRITE, a);
        hostAcc(1'b1, 32'h000a_0000, 1'b0, dcsc_pkg::CMD_DESEL, a);
        $display("legacy window test done");
    endtask
    task automatic testModes();
        logic [2:0] order [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
        dcsc_pkg::dcsc_cmd_t expCmd [8] = '{dcsc_pkg::CMD_WRITE, dcsc_pkg::CMD_NOP, dcsc_pkg::CMD_PRE,
            dcsc_pkg::CMD_MRS, dcsc_pkg::CMD_CBR, dcsc_pkg::CMD_NOP, dcsc_pkg::CMD_NOP, dcsc_pkg::CMD_NOP};
        logic [11:0] a;
        regAcc(1'b1, 1'b0, dcsc_pkg::LEGACY_WR_ADDR, 8'h02, 1'b1, 8'h00);
        for (int i = 0; i < 8; i++) begin
            regAcc(1'b1, 1'b1, dcsc_pkg::CTL_HIGH_ADDR, {5'h01, order[i]}, 1'b1, 8'h00);
            check(32'(specialMode), 32'(order[i]));
            hostAcc(1'b1, 32'h000a_10c8, 1'b1, expCmd[order[i]], a);
            if (order[i] == dcsc_pkg::MODE_MRS) begin
                check(32'(a), 32'h0000_0032);
            end
            if (order[i] == dcsc_pkg::MODE_PRECHARGE) begin
                check(32'(a[dcsc_pkg::AP_BIT]), 32'h0000_0001);
            end
        end
        check(32'(orderFault), 32'h0000_0000);
        $display("special mode test done");
    endtask
    task automatic testRefresh();
        logic [15:0] start;
        start = refreshCount;
        repeat (2 * dcsc_pkg::REFRESH_CYCLES) @(negedge clk);
        check(32'(refreshCount - start), 32'h0000_0002);
        regAcc(1'b1, 1'b1, dcsc_pkg::CTL_HIGH_ADDR, 8'h00, 1'b1, 8'h00);
        check(32'(refreshRate), 32'(dcsc_pkg::RATE_OFF));
        start = refreshCount;
        repeat (2 * dcsc_pkg::REFRESH_CYCLES) @(negedge clk);
        check(32'(refreshCount - start), 32'h0000_0000);
        regAcc(1'b1, 1'b1, dcsc_pkg::CTL_HIGH_ADDR, 8'h08, 1'b1, 8'h00);
        $display("refresh test done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        testRegisters();
        testLegacy();
        testModes();
        testRefresh();
        finalReport();
    end
endmodule
